//--- bdis_top.sv
// backlight driver register file behind a two-wire serial slave
`timescale 1ns/1ns
module bdis_top #(
    parameter logic [6:0] DEV_ADDR = 7'h2a
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // serial bus, open drain data
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    // brightness pulse input
    input wire logic pwm_in,
    // bank controls
    output logic bank_a_enable_out,
    output logic bank_b_enable_out,
    output logic linear_mapping_out,
    output logic bank_a_pwm_enable_out,
    output logic bank_b_pwm_enable_out,
    output logic bank_a_feedback_enable_out,
    output logic bank_b_feedback_enable_out,
    // boost settings
    output logic [1:0] overvoltage_limit_select_out,
    output logic [1:0] overcurrent_limit_select_out,
    output logic boost_frequency_select_out,
    // input conditioning and sampler
    output logic [1:0] input_filter_level_out,
    output logic [1:0] sampler_hysteresis_out,
    output logic [3:0] sampler_lower_bound_out,
    // sink currents in microamps
    output logic [15:0] bank_a_current_ua_out,
    output logic [15:0] bank_b_current_ua_out
);
    import bdis_pkg::*;

    // ==========================================================
    // reset release
    logic rst_meta_q;
    logic rst_n_q;

    // two-stage release, assert stays asynchronous
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // ==========================================================
    // bus events
    logic scl_rise;
    logic scl_fall;
    logic start_p;
    logic stop_p;

    bdis_bus_events u_events (
        .clk_in(clk_in),
        .rst_n_in(rst_n_q),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .scl_rise_out(scl_rise),
        .scl_fall_out(scl_fall),
        .start_out(start_p),
        .stop_out(stop_p)
    );

    // ==========================================================
    // registers
    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] cfg_q, cfg_d;
    logic [7:0] boost_q, boost_d;
    logic [7:0] brt_a_q, brt_a_d;
    logic [7:0] brt_b_q, brt_b_d;
    logic [7:0] fs_a_q, fs_a_d;
    logic [7:0] fs_b_q, fs_b_d;
    logic [1:0] fltr_q, fltr_d;
    logic wr_en;
    logic [7:0] rd_data;
    logic [7:0] rd_next;

    // read mux shared by first byte and follow-on bytes
    function automatic logic [7:0] reg_read(input logic [7:0] off,
            input logic [7:0] c0, input logic [7:0] c1,
            input logic [7:0] c2, input logic [7:0] c3,
            input logic [7:0] c4, input logic [7:0] c5,
            input logic [7:0] c6, input logic [1:0] f);
        logic [7:0] r;
        r = UNMAPPED_READ;
        case (off)
            OFF_CTRL: r = c0;
            OFF_CFG: r = c1;
            OFF_BOOST: r = c2;
            OFF_BRT_A: r = c3;
            OFF_BRT_B: r = c4;
            OFF_FS_A: r = c5;
            OFF_FS_B: r = c6;
            OFF_FLTR: r = {6'h00, f};
            default: r = UNMAPPED_READ;
        endcase
        return r;
    endfunction

    // ==========================================================
    // slave protocol
    bdis_state_t state_q, state_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] shift_q, shift_d;
    logic [7:0] ptr_q, ptr_d;
    logic rw_q, rw_d;
    logic drive_q, drive_d;
    logic ack_q, ack_d;

    assign rd_data = reg_read(ptr_q, ctrl_q, cfg_q, boost_q, brt_a_q,
        brt_b_q, fs_a_q, fs_b_q, fltr_q);
    assign rd_next = reg_read(ptr_q + PTR_ONE, ctrl_q, cfg_q, boost_q,
        brt_a_q, brt_b_q, fs_a_q, fs_b_q, fltr_q);

    // bits taken on clock rise, data and ack changed on clock fall
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        shift_d = shift_q;
        ptr_d = ptr_q;
        rw_d = rw_q;
        drive_d = drive_q;
        ack_d = ack_q;
        wr_en = 1'b0;
        if (start_p) begin
            state_d = ST_ADDR;
            cnt_d = '0;
            drive_d = 1'b0;
        end else if (stop_p) begin
            state_d = ST_IDLE;
            drive_d = 1'b0;
        end else begin
            case (state_q)
                ST_ADDR, ST_PTR, ST_WDATA: begin
                    if (scl_rise) begin
                        shift_d = {shift_q[6:0], sda_in};
                        cnt_d = cnt_q + CNT_ONE;
                    end else if (scl_fall && cnt_q == BYTE_BITS) begin
                        cnt_d = '0;
                        drive_d = 1'b1;
                        if (state_q == ST_ADDR) begin
                            rw_d = shift_q[0];
                            state_d = ST_ADDR_ACK;
                            // foreign address: stay off the bus
                            if (shift_q[7:1] != DEV_ADDR) begin
                                state_d = ST_IDLE;
                                drive_d = 1'b0;
                            end
                        end else if (state_q == ST_PTR) begin
                            ptr_d = shift_q;
                            state_d = ST_PTR_ACK;
                        end else begin
                            wr_en = 1'b1;
                            state_d = ST_WDATA_ACK;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (rw_q) begin
                            shift_d = rd_data;
                            drive_d = ~rd_data[7];
                            cnt_d = '0;
                            state_d = ST_RDATA;
                        end else begin
                            drive_d = 1'b0;
                            state_d = ST_PTR;
                        end
                    end
                end
                ST_PTR_ACK: begin
                    if (scl_fall) begin
                        drive_d = 1'b0;
                        state_d = ST_WDATA;
                    end
                end
                ST_WDATA_ACK: begin
                    // pointer steps so bursts fill consecutive offsets
                    if (scl_fall) begin
                        drive_d = 1'b0;
                        ptr_d = ptr_q + PTR_ONE;
                        state_d = ST_WDATA;
                    end
                end
                ST_RDATA: begin
                    if (scl_fall) begin
                        if (cnt_q == LAST_BIT) begin
                            drive_d = 1'b0;
                            cnt_d = '0;
                            state_d = ST_RDATA_ACK;
                        end else begin
                            shift_d = {shift_q[6:0], 1'b0};
                            drive_d = ~shift_q[6];
                            cnt_d = cnt_q + CNT_ONE;
                        end
                    end
                end
                ST_RDATA_ACK: begin
                    if (scl_rise) begin
                        ack_d = ~sda_in;
                    end else if (scl_fall) begin
                        if (ack_q) begin
                            ptr_d = ptr_q + PTR_ONE;
                            shift_d = rd_next;
                            drive_d = ~rd_next[7];
                            state_d = ST_RDATA;
                        end else begin
                            state_d = ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_d = ST_IDLE;
                    drive_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
            shift_q <= '0;
            ptr_q <= '0;
            rw_q <= 1'b0;
            drive_q <= 1'b0;
            ack_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            shift_q <= shift_d;
            ptr_q <= ptr_d;
            rw_q <= rw_d;
            drive_q <= drive_d;
            ack_q <= ack_d;
        end
    end

    // open drain: only ever pull low
    assign sda_out = 1'b0;
    assign sda_oe_out = drive_q;

    // ==========================================================
    // register writes, unmapped offsets are dropped
    always_comb begin
        ctrl_d = ctrl_q;
        cfg_d = cfg_q;
        boost_d = boost_q;
        brt_a_d = brt_a_q;
        brt_b_d = brt_b_q;
        fs_a_d = fs_a_q;
        fs_b_d = fs_b_q;
        fltr_d = fltr_q;
        if (wr_en) begin
            case (ptr_q)
                OFF_CTRL: ctrl_d = shift_q;
                OFF_CFG: cfg_d = shift_q;
                OFF_BOOST: boost_d = shift_q;
                OFF_BRT_A: brt_a_d = shift_q;
                OFF_BRT_B: brt_b_d = shift_q;
                OFF_FS_A: fs_a_d = shift_q;
                OFF_FS_B: fs_b_d = shift_q;
                OFF_FLTR: fltr_d = shift_q[FLTR_W-1:0];
                default: ctrl_d = ctrl_q;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ctrl_q <= REG_RESET;
            cfg_q <= REG_RESET;
            boost_q <= REG_RESET;
            brt_a_q <= REG_RESET;
            brt_b_q <= REG_RESET;
            fs_a_q <= REG_RESET;
            fs_b_q <= REG_RESET;
            fltr_q <= FLTR_RESET;
        end else begin
            ctrl_q <= ctrl_d;
            cfg_q <= cfg_d;
            boost_q <= boost_d;
            brt_a_q <= brt_a_d;
            brt_b_q <= brt_b_d;
            fs_a_q <= fs_a_d;
            fs_b_q <= fs_b_d;
            fltr_q <= fltr_d;
        end
    end

    // ==========================================================
    // field decode
    assign bank_a_enable_out = ctrl_q[CTRL_A_EN_BIT];
    assign bank_b_enable_out = ctrl_q[CTRL_B_EN_BIT];
    assign linear_mapping_out = ctrl_q[CTRL_LINEAR_BIT];
    assign bank_a_pwm_enable_out = cfg_q[CFG_A_PWM_BIT];
    assign bank_a_feedback_enable_out = cfg_q[CFG_A_FB_BIT];
    assign bank_b_pwm_enable_out = cfg_q[CFG_B_PWM_BIT];
    assign bank_b_feedback_enable_out = cfg_q[CFG_B_FB_BIT];
    assign overvoltage_limit_select_out =
        boost_q[BOOST_OVP_LO +: LIMIT_W];
    assign overcurrent_limit_select_out =
        boost_q[BOOST_OCP_LO +: LIMIT_W];
    assign boost_frequency_select_out = boost_q[BOOST_FREQ_BIT];
    assign input_filter_level_out = fltr_q;
    // bank A's register carries the sampler setup for both banks
    assign sampler_hysteresis_out = fs_a_q[FS_HYST_BIT] ?
        HYST_CODES_SET : HYST_CODES_CLR;
    assign sampler_lower_bound_out = fs_a_q[FS_LB_BIT] ?
        LOWER_BOUND_SET : LOWER_BOUND_CLR;

    // ==========================================================
    // sink current: full scale times brightness over 255
    function automatic logic [15:0] sink_ua(input logic [7:0] fs,
            input logic [7:0] br, input logic lin);
        logic [15:0] sq;
        logic [7:0] eff;
        logic [22:0] prod;
        sq = {8'h00, br} * {8'h00, br};
        // square law stands in for the non-linear curve
        eff = lin ? br : 8'(sq / SQ_FULL);
        prod = 23'(fs[FS_CODE_W-1:0]) * UA_PER_CODE * 23'(eff);
        return 16'(prod / BRIGHT_FULL);
    endfunction

    logic [15:0] cur_a_q, cur_a_d;
    logic [15:0] cur_b_q, cur_b_d;
    logic on_a;
    logic on_b;

    // a pulse-width-enabled bank follows the pwm pin level
    always_comb begin
        on_a = bank_a_enable_out & (~bank_a_pwm_enable_out | pwm_in);
        on_b = bank_b_enable_out & (~bank_b_pwm_enable_out | pwm_in);
        cur_a_d = on_a ? sink_ua(fs_a_q, brt_a_q, linear_mapping_out)
            : 16'h0000;
        cur_b_d = on_b ? sink_ua(fs_b_q, brt_b_q, linear_mapping_out)
            : 16'h0000;
    end

    always_ff @(posedge clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cur_a_q <= 16'h0000;
            cur_b_q <= 16'h0000;
        end else begin
            cur_a_q <= cur_a_d;
            cur_b_q <= cur_b_d;
        end
    end

    assign bank_a_current_ua_out = cur_a_q;
    assign bank_b_current_ua_out = cur_b_q;

    // ==========================================================
    // checks
    default clocking dcb @(posedge clk_in); endclocking
    default disable iff (!rst_n_q);

    AST_CFG_BANK_A: assert property (
        wr_en && ptr_q == OFF_CFG && shift_q == 8'h09 |=>
        bank_a_pwm_enable_out && bank_a_feedback_enable_out)
        else $error("config 09h did not enable bank A");
    AST_CFG_BANK_B_OFF: assert property (
        wr_en && ptr_q == OFF_CFG && !shift_q[CFG_B_FB_BIT]
        && !shift_q[CFG_B_PWM_BIT] |=>
        !bank_b_feedback_enable_out && !bank_b_pwm_enable_out)
        else $error("bank B not disabled by cleared bits");
    AST_BOOST_SEL: assert property (
        wr_en && ptr_q == OFF_BOOST && shift_q == 8'h78 |=>
        overvoltage_limit_select_out == 2'h3
        && overcurrent_limit_select_out == 2'h3
        && !boost_frequency_select_out)
        else $error("boost 78h decoded wrongly");
    AST_FULL_SCALE_B: assert property (
        wr_en && ptr_q == OFF_FS_B |=> fs_b_q == $past(shift_q))
        else $error("bank B full scale not stored");
    AST_HYST: assert property (
        wr_en && ptr_q == OFF_FS_A && shift_q[FS_HYST_BIT] |=>
        sampler_hysteresis_out == 2'h2)
        else $error("hysteresis not 2 codes");
    AST_LOWER_BOUND: assert property (
        wr_en && ptr_q == OFF_FS_A && !shift_q[FS_LB_BIT] |=>
        sampler_lower_bound_out == 4'h6)
        else $error("lower bound not code 6");
    AST_CTRL_14: assert property (
        wr_en && ptr_q == OFF_CTRL && shift_q == 8'h14 |=>
        linear_mapping_out && bank_a_enable_out && !bank_b_enable_out)
        else $error("control 14h decoded wrongly");
    AST_FULL_CURRENT: assert property (
        (fs_a_q[FS_CODE_W-1:0] == 5'h14 && brt_a_q == 8'hff
        && linear_mapping_out && bank_a_enable_out && pwm_in) [*2] |->
        bank_a_current_ua_out == 16'd20000)
        else $error("bank A not at 20 mA");

    COV_WRITE: cover property (wr_en ##[1:300] state_q == ST_IDLE);
    COV_READ: cover property (state_q == ST_RDATA_ACK && scl_fall);
    COV_LIGHT: cover property (bank_a_current_ua_out != 16'h0000);

endmodule

//--- bdis_pkg.sv
// constants, register map and state encoding of the backlight init sequencer
// Operation
// - writing 09h to the configuration register at 01h enables pulse-width input and feedback for bank A.
// - clearing configuration bit 4 disables bank B feedback and clearing bit 1 disables bank B pulse-width control.
// - the boost settings register at 02h picks overvoltage, overcurrent and frequency, 78h giving 40 V, 1.2 A, 500 kHz.
// - bank A full-scale current sits at 05h and bank B at 06h, code 14h meaning 20 mA.
// - bit 7 of the bank A full-scale register gives the pulse-width sampler a hysteresis of 2 codes for both banks.
// - a clear bit 6 of the bank A full-scale register sets the sampler lower bound to code 6 for both banks.
// - the control register at 00h picks the current mapping and bank enables, 14h giving linear mapping with bank A on.
// - bank A brightness sits at 03h and bank B at 04h, FFh with full scale 14h and pulse-width high giving 20 mA.
package bdis_pkg;

    // ==========================================================
    // register offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_CFG = 8'h01;
    localparam logic [7:0] OFF_BOOST = 8'h02;
    localparam logic [7:0] OFF_BRT_A = 8'h03;
    localparam logic [7:0] OFF_BRT_B = 8'h04;
    localparam logic [7:0] OFF_FS_A = 8'h05;
    localparam logic [7:0] OFF_FS_B = 8'h06;
    localparam logic [7:0] OFF_FLTR = 8'h50;

    // ==========================================================
    // reset values and unmapped answer
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [1:0] FLTR_RESET = 2'h0;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ==========================================================
    // field positions
    localparam int CTRL_A_EN_BIT = 2;
    localparam int CTRL_B_EN_BIT = 3;
    localparam int CTRL_LINEAR_BIT = 4;
    localparam int CFG_A_PWM_BIT = 0;
    localparam int CFG_B_PWM_BIT = 1;
    localparam int CFG_A_FB_BIT = 3;
    localparam int CFG_B_FB_BIT = 4;
    localparam int BOOST_FREQ_BIT = 0;
    localparam int BOOST_OCP_LO = 3;
    localparam int BOOST_OVP_LO = 5;
    localparam int LIMIT_W = 2;
    localparam int FS_CODE_W = 5;
    localparam int FS_LB_BIT = 6;
    localparam int FS_HYST_BIT = 7;
    localparam int FLTR_W = 2;

    // ==========================================================
    // sampler settings and current scaling
    localparam logic [1:0] HYST_CODES_SET = 2'h2;
    localparam logic [1:0] HYST_CODES_CLR = 2'h1;
    localparam logic [3:0] LOWER_BOUND_CLR = 4'h6;
    localparam logic [3:0] LOWER_BOUND_SET = 4'h4;
    localparam logic [22:0] UA_PER_CODE = 23'h0003e8;
    localparam logic [22:0] BRIGHT_FULL = 23'h0000ff;
    localparam logic [15:0] SQ_FULL = 16'h00ff;

    // ==========================================================
    // serial bus bit counts
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [3:0] CNT_ONE = 4'h1;
    localparam logic [7:0] PTR_ONE = 8'h01;

    // slave protocol states, gray along the write path
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_ADDR_ACK = 4'h3,
        ST_PTR = 4'h2,
        ST_PTR_ACK = 4'h6,
        ST_WDATA = 4'h7,
        ST_WDATA_ACK = 4'h5,
        ST_RDATA = 4'h4,
        ST_RDATA_ACK = 4'hc
    } bdis_state_t;

endpackage

//--- bdis_bus_events.sv
// serial bus edge, start and stop detector
`timescale 1ns/1ns
module bdis_bus_events (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    // events
    output logic scl_rise_out,
    output logic scl_fall_out,
    output logic start_out,
    output logic stop_out
);
    import bdis_pkg::*;

    logic scl_q;
    logic scl_d;
    logic sda_q;
    logic sda_d;

    // previous pin levels
    always_comb begin
        scl_d = scl_in;
        sda_d = sda_in;
    end

    // idle bus is high, so reset to high to avoid a false edge
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_d;
            sda_q <= sda_d;
        end
    end

    // data moving while clock high marks start or stop
    assign scl_rise_out = scl_in & ~scl_q;
    assign scl_fall_out = ~scl_in & scl_q;
    assign start_out = scl_in & scl_q & sda_q & ~sda_in;
    assign stop_out = scl_in & scl_q & ~sda_q & sda_in;

endmodule

//--- bdis_host.sv
// serial bus host model driving the sequencer's two-wire port
`timescale 1ns/1ns
module bdis_host (
    // clock
    input wire logic clk_in,
    // bus lines, sda_in is the resolved wire
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_low_out
);
    // ==========================================
    // idle bus: clock high, data released
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    // four clocks a phase keeps well above the two-clock minimum
    task automatic half();
        repeat (4) @(negedge clk_in);
    endtask
    // start also serves as repeated start from a low clock
    task automatic start();
        @(negedge clk_in);
        sda_low_out = 1'b0;
        half();
        scl_out = 1'b1;
        half();
        sda_low_out = 1'b1;
        half();
        scl_out = 1'b0;
    endtask
    task automatic stop();
        @(negedge clk_in);
        sda_low_out = 1'b1;
        half();
        scl_out = 1'b1;
        half();
        sda_low_out = 1'b0;
        half();
    endtask
    // data moves one clock after the fall, so no false start or stop
    task automatic bit_io(input logic b, output logic seen);
        @(negedge clk_in);
        sda_low_out = ~b;
        half();
        scl_out = 1'b1;
        half();
        seen = sda_in;
        scl_out = 1'b0;
    endtask
    task automatic byte_io(input logic [7:0] b, input logic ack_in,
        output logic [7:0] seen, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], s);
            seen[i] = s;
        end
        bit_io(ack_in, s);
        ack = ~s;
    endtask
    // ==========================================
    // one register access; a refused byte ends the frame at once
    task automatic access(input logic [6:0] dev, input logic rd,
        input logic [7:0] off, input logic [7:0] wval,
        output logic [7:0] rval, output logic ok);
        logic a;
        logic [7:0] junk;
        rval = 8'h00;
        start();
        byte_io({dev, 1'b0}, 1'b1, junk, a);
        ok = a;
        if (ok) begin
            byte_io(off, 1'b1, junk, a);
            ok = a;
        end
        if (ok && !rd) begin
            byte_io(wval, 1'b1, junk, a);
            ok = a;
        end
        if (ok && rd) begin
            start();
            byte_io({dev, 1'b1}, 1'b1, junk, a);
            ok = a;
            if (ok) begin
                byte_io(8'hff, 1'b1, rval, a);
            end
        end
        stop();
    endtask
endmodule

//--- tb_top.sv
// self-checking bench for the backlight init sequencer
`timescale 1ns/1ns
module tb_top;
    import bdis_pkg::*;
    localparam logic [6:0] DEV = 7'h2a;
    logic clk_in, nrst_in, pwm_in, scl, host_low, sda_line;
    logic sda_out, sda_oe_out, a_en, b_en, lin, a_pwm, b_pwm, a_fb, b_fb;
    logic [1:0] overvoltage_limit_select, overcurrent_limit_select, fltr, hyst;
    logic freq;
    logic [3:0] lb;
    logic [15:0] cur_a, cur_b;
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;
    // open drain wire with pull-up
    assign sda_line = ~((sda_oe_out & ~sda_out) | host_low);
    bdis_top #(.DEV_ADDR(DEV)) bdis_top_inst (.clk_in(clk_in),
        .nrst_in(nrst_in), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe_out(sda_oe_out), .pwm_in(pwm_in),
        .bank_a_enable_out(a_en), .bank_b_enable_out(b_en),
        .linear_mapping_out(lin), .bank_a_pwm_enable_out(a_pwm),
        .bank_b_pwm_enable_out(b_pwm), .bank_a_feedback_enable_out(a_fb),
        .bank_b_feedback_enable_out(b_fb),
        .overvoltage_limit_select_out(overvoltage_limit_select),
        .overcurrent_limit_select_out(overcurrent_limit_select),
        .boost_frequency_select_out(freq), .input_filter_level_out(fltr),
        .sampler_hysteresis_out(hyst), .sampler_lower_bound_out(lb),
        .bank_a_current_ua_out(cur_a), .bank_b_current_ua_out(cur_b));
    bdis_host bdis_host_inst (.clk_in(clk_in), .sda_in(sda_line),
        .scl_out(scl), .sda_low_out(host_low));
    // ==========================================
    // clock and hang guard
    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [15:0] seen,
        input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // ==========================================
    // register access helpers
    task automatic wr(input logic [7:0] off, input logic [7:0] v);
        logic ok;
        logic [7:0] r;
        bdis_host_inst.access(DEV, 1'b0, off, v, r, ok);
        check("write ack", 16'(ok), 16'h0001);
        repeat (3) @(negedge clk_in);
    endtask
    task automatic rd(input logic [7:0] off, output logic [7:0] v);
        logic ok;
        bdis_host_inst.access(DEV, 1'b1, off, 8'h00, v, ok);
    endtask
    // ==========================================
    // scenarios
    task automatic t_reset();
        check("hyst", 16'(hyst), 16'h0001);
        check("lower", 16'(lb), 16'h0006);
        check("ctrl", 16'({a_en, b_en, lin, a_pwm, a_fb}), 16'h0);
    endtask
    // documented order, host side
    task automatic t_init();
        pwm_in = 1'b1;
        wr(OFF_FLTR, 8'h03);
        check("filter", 16'(fltr), 16'h0003);
        wr(OFF_CFG, 8'h09);
        check("a pwm fb", 16'({a_pwm, a_fb}), 16'h0003);
        check("b pwm fb", 16'({b_pwm, b_fb}), 16'h0000);
        wr(OFF_BOOST, 8'h78);
        check("boost", 16'({overvoltage_limit_select, overcurrent_limit_select, freq}), 16'h001e);
        wr(OFF_FS_A, 8'h94);
        check("hyst", 16'(hyst), 16'h0002);
        check("lower", 16'(lb), 16'h0006);
        check("cur a off", cur_a, 16'h0000);
        wr(OFF_CTRL, 8'h14);
        check("ctrl", 16'({a_en, b_en, lin}), 16'h0005);
        wr(OFF_BRT_A, 8'hff);
        check("cur a", cur_a, 16'd20000);
        pwm_in = 1'b0;
        repeat (3) @(negedge clk_in);
        check("cur a pwm low", cur_a, 16'h0000);
        pwm_in = 1'b1;
    endtask
    task automatic t_bank_b();
        wr(OFF_CFG, 8'h1b);
        check("b pwm fb", 16'({b_pwm, b_fb}), 16'h0003);
        wr(OFF_FS_B, 8'h14);
        wr(OFF_CTRL, 8'h1c);
        wr(OFF_BRT_B, 8'h80);
        check("cur b", cur_b, 16'd10039);
        wr(OFF_CTRL, 8'h0c);
        check("ctrl sq", 16'({a_en, b_en, lin}), 16'h0006);
        check("cur b sq", cur_b, 16'd5019);
        check("cur a sq", cur_a, 16'd20000);
        wr(OFF_FS_A, 8'h54);
        check("hyst", 16'(hyst), 16'h0001);
        check("lower", 16'(lb), 16'h0004);
        check("cur a", cur_a, 16'd20000);
        wr(OFF_CFG, 8'h09);
        check("b pwm fb", 16'({b_pwm, b_fb}), 16'h0000);
    endtask
    // foreign address, unmapped place and read-back
    task automatic t_refuse();
        logic ok;
        logic [7:0] v;
        bdis_host_inst.access(7'h15, 1'b0, OFF_CTRL, 8'h00, v, ok);
        check("foreign ack", 16'(ok), 16'h0000);
        check("ctrl kept", 16'(a_en), 16'h0001);
        bdis_host_inst.access(DEV, 1'b0, 8'h07, 8'h55, v, ok);
        rd(8'h07, v);
        check("unmapped", 16'(v), 16'h0000);
        rd(OFF_FS_B, v);
        check("fs b", 16'(v), 16'h0014);
        rd(OFF_FLTR, v);
        check("filter rd", 16'(v), 16'h0003);
    endtask
    initial begin
        nrst_in = 1'b0;
        pwm_in = 1'b0;
        repeat (4) @(negedge clk_in);
        nrst_in = 1'b1;
        repeat (4) @(negedge clk_in);
        t_reset();
        t_init();
        t_bank_b();
        t_refuse();
        end_of_test();
    end
endmodule
